// ===== rtl/pic_pkg.sv
// constants, types and helpers shared by the prioritised interrupt controller
`default_nettype none
package pic_pkg;
  localparam int AXI_AW = 8;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;

  localparam logic [AXI_AW-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_CTRL2 = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_MFI = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_STAT = 8'h10;

  localparam int C0_GLOBAL_EN = 0;
  localparam int C0_PIN_EN = 1;
  localparam int C0_MF_EN = 2;
  localparam int C0_TB0_EN = 3;
  localparam int C0_PIN_FLAG = 4;
  localparam int C0_MF_FLAG = 5;
  localparam int C0_TB0_FLAG = 6;
  localparam int C1_TB1_EN = 0;
  localparam int C1_CONV_EN = 1;
  localparam int C1_EEP_EN = 2;
  localparam int C1_SER_EN = 3;
  localparam int C1_TB1_FLAG = 4;
  localparam int C1_CONV_FLAG = 5;
  localparam int C1_EEP_FLAG = 6;
  localparam int C1_SER_FLAG = 7;
  localparam int C2_UART_EN = 0;
  localparam int C2_UART_FLAG = 4;
  // timer lanes: 0 compact p, 1 compact a, 2 periodic p, 3 periodic a
  localparam int MFI_EN_LSB = 0;
  localparam int MFI_FLAG_LSB = 4;

  localparam logic [7:0] C0_MASK = 8'h7F;
  localparam logic [7:0] C1_MASK = 8'hFF;
  localparam logic [7:0] C2_MASK = 8'h11;
  localparam logic [7:0] MFI_MASK = 8'hFF;
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_MFI = 8'h00;

  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_SRC_LSB = 2;
  localparam int ST_SRC_VALID = 5;
  localparam int ST_LEVEL_LSB = 8;

  // index order is the priority order, 0 highest
  localparam logic [SRC_W-1:0] SRC_PIN = 3'h0;
  localparam logic [SRC_W-1:0] SRC_SER = 3'h1;
  localparam logic [SRC_W-1:0] SRC_EEP = 3'h2;
  localparam logic [SRC_W-1:0] SRC_CONV = 3'h3;
  localparam logic [SRC_W-1:0] SRC_MF = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TB0 = 3'h5;
  localparam logic [SRC_W-1:0] SRC_TB1 = 3'h6;
  localparam logic [SRC_W-1:0] SRC_UART = 3'h7;

  localparam logic [PC_W-1:0] VEC_BASE = 12'h004;
  localparam logic [PC_W-1:0] VEC_STEP = 12'h004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SEL_CTRL0, SEL_CTRL1, SEL_CTRL2, SEL_MFI, SEL_STAT, SEL_NONE} pic_sel_type;

  function automatic pic_sel_type pic_decode(input logic [AXI_AW-1:0] addr);
    logic [AXI_AW-1:0] word;
    word = {addr[AXI_AW-1:2], 2'h0};
    case (word)
      OFS_CTRL0: pic_decode = SEL_CTRL0;
      OFS_CTRL1: pic_decode = SEL_CTRL1;
      OFS_CTRL2: pic_decode = SEL_CTRL2;
      OFS_MFI: pic_decode = SEL_MFI;
      OFS_STAT: pic_decode = SEL_STAT;
      default: pic_decode = SEL_NONE;
    endcase
  endfunction

  // one vector per vectored source; timers only reach the multi vector
  function automatic logic [PC_W-1:0] pic_vector(input logic [SRC_W-1:0] idx);
    logic [2*PC_W-1:0] prod;
    prod = VEC_STEP * {{(PC_W-SRC_W){1'b0}}, idx};
    pic_vector = VEC_BASE + prod[PC_W-1:0];
  endfunction
endpackage
`default_nettype wire

// ===== rtl/pic_core_if.sv
// bundle between the controller, its arbiter and its return stack
`timescale 1ns/10ps
`default_nettype none
interface pic_core_if #(parameter int PC_W = 12, parameter int DEPTH = 4, parameter int NUM_SRC = 8,
                        parameter int SRC_W = 3);
  logic [NUM_SRC-1:0] req;
  logic grant_valid;
  logic [SRC_W-1:0] grant_idx;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] top_data;
  logic full;
  logic empty;
  logic [$clog2(DEPTH+1)-1:0] level;
  modport ctl (output req, input grant_valid, input grant_idx, output push, output pop, output push_data,
               input top_data, input full, input empty, input level);
  modport arb (input req, output grant_valid, output grant_idx);
  modport stk (input push, input pop, input push_data, output top_data, output full, output empty,
               output level);
endinterface
`default_nettype wire

// ===== rtl/pic_arbiter.sv
// fixed priority selection among enabled requests
`timescale 1ns/10ps
`default_nettype none
module pic_arbiter #(
  parameter int NUM_SRC = 8,
  parameter int SRC_W = 3
) (
  pic_core_if.arb core
);
  import pic_pkg::*;

  // purely combinational so the grant belongs to the cycle the requests are seen
  always_comb
  begin
    core.grant_valid = 1'b0;
    core.grant_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (core.req[i])
      begin
        core.grant_valid = 1'b1;
        core.grant_idx = SRC_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pic_stack.sv
// return address stack for interrupt entry and return
`timescale 1ns/10ps
`default_nettype none
module pic_stack #(
  parameter int PC_W = 12,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  pic_core_if.stk core
);
  import pic_pkg::*;

  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [LW-1:0] sp;
  } pic_stack_type;

  pic_stack_type r;
  pic_stack_type n;
  logic [LW-1:0] top_idx;

  assign top_idx = (r.sp == '0) ? '0 : LW'(r.sp - LW'(1));
  assign core.top_data = r.mem[top_idx];
  assign core.full = (r.sp == LW'(DEPTH));
  assign core.empty = (r.sp == '0);
  assign core.level = r.sp;

  always_comb
  begin
    n = r;
    if (core.push && !core.full)
    begin
      n.mem[r.sp] = core.push_data;
      n.sp = LW'(r.sp + LW'(1));
    end
    else if (core.pop && !core.empty)
    begin
      n.sp = LW'(r.sp - LW'(1));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end
endmodule
`default_nettype wire

// ===== rtl/pic_top.sv
// interrupt controller top: register file, flag logic, entry and return sequencing
`timescale 1ns/10ps
`default_nettype none
module pic_top #(
  parameter int PC_W = pic_pkg::PC_W,
  parameter int STACK_DEPTH = pic_pkg::STACK_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pic_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pic_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_pin,
  input wire logic ev_time_base_zero,
  input wire logic ev_time_base_one,
  input wire logic ev_serial_module,
  input wire logic ev_eeprom_write,
  input wire logic ev_conversion,
  input wire logic ev_uart,
  input wire logic [3:0] ev_timer_match,
  input wire logic cpu_ready,
  input wire logic [PC_W-1:0] cpu_pc_next,
  input wire logic cpu_return_from_interrupt,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_addr,
  output logic irq_taken,
  output logic [pic_pkg::SRC_W-1:0] irq_source,
  output logic wake_req
);
  import pic_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] multi_function_irq_control;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pc_load;
    logic [PC_W-1:0] pc_addr;
    logic taken;
    logic [SRC_W-1:0] last_src;
    logic src_valid;
    logic wake;
  } pic_state_type;

  localparam pic_state_type STATE_RST = '{
    ctrl0: RST_CTRL0,
    ctrl1: RST_CTRL1,
    ctrl2: RST_CTRL2,
    multi_function_irq_control: RST_MFI,
    default: '0
  };

  pic_state_type r;
  pic_state_type n;

  pic_core_if #(.PC_W(PC_W), .DEPTH(STACK_DEPTH), .NUM_SRC(NUM_SRC), .SRC_W(SRC_W)) core ();

  logic pin_edge;
  logic take;
  logic ret;
  logic global_en;

  // every flag bit of the four registers, in one vector, for wake detection
  function automatic logic [11:0] flag_bits(input logic [7:0] c0, input logic [7:0] c1,
                                            input logic [7:0] c2, input logic [7:0] mf);
    flag_bits = {c0[C0_TB0_FLAG:C0_PIN_FLAG], c1[C1_SER_FLAG:C1_TB1_FLAG], c2[C2_UART_FLAG],
                 mf[MFI_FLAG_LSB+3:MFI_FLAG_LSB]};
  endfunction

  pic_arbiter #(.NUM_SRC(NUM_SRC), .SRC_W(SRC_W)) u_arbiter (
    .core(core.arb)
  );

  pic_stack #(.PC_W(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .core(core.stk)
  );

  // per-source enable gating; the arbiter only sees enabled requests
  always_comb
  begin
    core.req = '0;
    core.req[SRC_PIN] = r.ctrl0[C0_PIN_EN] & r.ctrl0[C0_PIN_FLAG];
    core.req[SRC_SER] = r.ctrl1[C1_SER_EN] & r.ctrl1[C1_SER_FLAG];
    core.req[SRC_EEP] = r.ctrl1[C1_EEP_EN] & r.ctrl1[C1_EEP_FLAG];
    core.req[SRC_CONV] = r.ctrl1[C1_CONV_EN] & r.ctrl1[C1_CONV_FLAG];
    core.req[SRC_MF] = r.ctrl0[C0_MF_EN] & r.ctrl0[C0_MF_FLAG];
    core.req[SRC_TB0] = r.ctrl0[C0_TB0_EN] & r.ctrl0[C0_TB0_FLAG];
    core.req[SRC_TB1] = r.ctrl1[C1_TB1_EN] & r.ctrl1[C1_TB1_FLAG];
    core.req[SRC_UART] = r.ctrl2[C2_UART_EN] & r.ctrl2[C2_UART_FLAG];
  end

  assign global_en = r.ctrl0[C0_GLOBAL_EN];
  // a return in the same cycle wins; the cpu is busy with it and cannot also enter
  assign take = global_en & cpu_ready & core.grant_valid & ~core.full & ~cpu_return_from_interrupt;
  assign ret = cpu_return_from_interrupt & ~core.empty;
  assign core.push = take;
  assign core.pop = ret;
  assign core.push_data = cpu_pc_next;
  assign pin_edge = r.pin_sync & ~r.pin_prev;

  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready = ~r.w_got & ~r.bvalid;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign pc_load = r.pc_load;
  assign pc_load_addr = r.pc_addr;
  assign irq_taken = r.taken;
  assign irq_source = r.last_src;
  assign wake_req = r.wake;

  always_comb
  begin
    pic_sel_type wr_sel;
    pic_sel_type rd_sel;
    logic do_write;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] mf;
    logic [31:0] rd;
    n = r;
    wr_sel = SEL_NONE;
    rd_sel = SEL_NONE;
    do_write = 1'b0;
    rd = '0;

    // pin synchroniser, edge taken after the second stage only
    n.pin_meta = ext_irq_pin;
    n.pin_sync = r.pin_meta;
    n.pin_prev = r.pin_sync;

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (n.aw_got && n.w_got)
    begin
      do_write = 1'b1;
      wr_sel = pic_decode(n.aw_addr);
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end

    // read channel: data from registered state, unmapped reads zero with an error
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rd_sel = pic_decode(s_axi_araddr);
      case (rd_sel)
        SEL_CTRL0: rd[7:0] = r.ctrl0 & C0_MASK;
        SEL_CTRL1: rd[7:0] = r.ctrl1 & C1_MASK;
        SEL_CTRL2: rd[7:0] = r.ctrl2 & C2_MASK;
        SEL_MFI: rd[7:0] = r.multi_function_irq_control & MFI_MASK;
        SEL_STAT:
        begin
          rd[ST_FULL] = core.full;
          rd[ST_EMPTY] = core.empty;
          rd[ST_SRC_LSB +: SRC_W] = r.last_src;
          rd[ST_SRC_VALID] = r.src_valid;
          rd[ST_LEVEL_LSB +: $bits(core.level)] = core.level;
        end
        default: rd = '0;
      endcase
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end

    // flags: hardware clear, then software write, then hardware set, so a set is never lost
    c0 = r.ctrl0;
    c1 = r.ctrl1;
    c2 = r.ctrl2;
    mf = r.multi_function_irq_control;
    if (take)
    begin
      c0[C0_GLOBAL_EN] = 1'b0;
      case (core.grant_idx)
        SRC_PIN: c0[C0_PIN_FLAG] = 1'b0;
        SRC_SER: c1[C1_SER_FLAG] = 1'b0;
        SRC_EEP: c1[C1_EEP_FLAG] = 1'b0;
        SRC_CONV: c1[C1_CONV_FLAG] = 1'b0;
        SRC_MF: c0[C0_MF_FLAG] = 1'b0;
        SRC_TB0: c0[C0_TB0_FLAG] = 1'b0;
        SRC_TB1: c1[C1_TB1_FLAG] = 1'b0;
        SRC_UART: c2[C2_UART_FLAG] = 1'b0;
        default: c0 = c0;
      endcase
    end
    if (do_write && n.wstrb0)
    begin
      case (wr_sel)
        SEL_CTRL0: c0 = n.wdata & C0_MASK;
        SEL_CTRL1: c1 = n.wdata & C1_MASK;
        SEL_CTRL2: c2 = n.wdata & C2_MASK;
        SEL_MFI: mf = n.wdata & MFI_MASK;
        default: c0 = c0;
      endcase
    end
    // events set flags whatever the enables and the global state
    c0[C0_PIN_FLAG] = c0[C0_PIN_FLAG] | pin_edge;
    c0[C0_TB0_FLAG] = c0[C0_TB0_FLAG] | ev_time_base_zero;
    c1[C1_TB1_FLAG] = c1[C1_TB1_FLAG] | ev_time_base_one;
    c1[C1_SER_FLAG] = c1[C1_SER_FLAG] | ev_serial_module;
    c1[C1_EEP_FLAG] = c1[C1_EEP_FLAG] | ev_eeprom_write;
    c1[C1_CONV_FLAG] = c1[C1_CONV_FLAG] | ev_conversion;
    c2[C2_UART_FLAG] = c2[C2_UART_FLAG] | ev_uart;
    mf[MFI_FLAG_LSB +: 4] = mf[MFI_FLAG_LSB +: 4] | ev_timer_match;
    // only a timer match whose own enable is set raises the shared flag
    c0[C0_MF_FLAG] = c0[C0_MF_FLAG] | (|(ev_timer_match & r.multi_function_irq_control[MFI_EN_LSB +: 4]));
    n.ctrl0 = c0;
    n.ctrl1 = c1;
    n.ctrl2 = c2;
    n.multi_function_irq_control = mf;

    // wake on a flag rising; a flag already set before sleep causes no wake
    n.wake = |(flag_bits(c0, c1, c2, mf) & ~flag_bits(r.ctrl0, r.ctrl1, r.ctrl2, r.multi_function_irq_control));

    // program counter redirect, one cycle after the decision
    n.pc_load = take | ret;
    n.taken = take;
    if (take)
    begin
      n.pc_addr = pic_vector(core.grant_idx);
      n.last_src = core.grant_idx;
      n.src_valid = 1'b1;
    end
    else if (ret)
      n.pc_addr = core.top_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= STATE_RST;
    else
      r <= n;
  end
endmodule
`default_nettype wire

// ===== testbench/pic_cpu_model.sv
// behavioural cpu sequencer facing the entry and return port of the controller
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model #(
  parameter int PC_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow,
  input wire logic ret_req,
  input wire logic [PC_W-1:0] pc_val,
  output logic cpu_ready,
  output logic [PC_W-1:0] cpu_pc_next,
  output logic cpu_return_from_interrupt
);
  logic [1:0] phase_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end
  // slow mode reaches an instruction boundary only one cycle in four, so entry latency varies
  assign cpu_ready = run && (!slow || phase_r == 2'h0);
  assign cpu_pc_next = pc_val;
  // return is only commanded while a routine is open, never on an empty stack
  assign cpu_return_from_interrupt = ret_req;
endmodule
`default_nettype wire

// ===== testbench/pic_top_assertions.sv
// concurrent checks on the interrupt controller top ports
`timescale 1ns/10ps
`default_nettype none
module pic_top_assertions #(
  parameter int PC_W = pic_pkg::PC_W,
  parameter int STACK_DEPTH = pic_pkg::STACK_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_ready,
  input wire logic cpu_return_from_interrupt,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_addr,
  input wire logic irq_taken,
  input wire logic [pic_pkg::SRC_W-1:0] irq_source
);
  import pic_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // open routines counted from entries and pops seen at the ports
  logic [3:0] depth_r;
  logic [3:0] depth_nxt;
  always_comb
  begin
    depth_nxt = depth_r;
    if (irq_taken)
      depth_nxt = depth_r + 4'h1;
    else if (pc_load)
      depth_nxt = depth_r - 4'h1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      depth_r <= 4'h0;
    else
      depth_r <= depth_nxt;
  end
  property p_entry_loads;
    irq_taken |-> pc_load;
  endproperty
  a_entry_loads: assert property (p_entry_loads) else $error("entry without pc load");
  property p_vector;
    irq_taken |-> pc_load_addr == PC_W'(VEC_BASE + VEC_STEP * irq_source);
  endproperty
  a_vector: assert property (p_vector) else $error("entry vector does not match source");
  property p_needs_ready;
    !cpu_ready |=> !irq_taken;
  endproperty
  a_needs_ready: assert property (p_needs_ready) else $error("entry without cpu boundary");
  property p_no_reentry;
    irq_taken && !s_axi_bvalid |=> !irq_taken;
  endproperty
  a_no_reentry: assert property (p_no_reentry) else $error("second entry without global re-enable");
  property p_stack_room;
    irq_taken |-> depth_r < STACK_DEPTH;
  endproperty
  a_stack_room: assert property (p_stack_room) else $error("entry taken with full stack");
  property p_return_pops;
    cpu_return_from_interrupt && depth_r != 4'h0 && !(pc_load && !irq_taken) |=> pc_load && !irq_taken;
  endproperty
  a_return_pops: assert property (p_return_pops) else $error("return did not load pc");
  property p_return_blocks;
    irq_taken |-> !$past(cpu_return_from_interrupt);
  endproperty
  a_return_blocks: assert property (p_return_blocks) else $error("entry in a return cycle");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write without response");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read without data");
  c_entry: cover property (irq_taken);
  c_full: cover property (depth_r == 4'h4 && !irq_taken);
  c_return: cover property (pc_load && !irq_taken);
endmodule
bind pic_top pic_top_assertions #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) pic_top_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .cpu_ready(cpu_ready), .cpu_return_from_interrupt(cpu_return_from_interrupt), .pc_load(pc_load),
  .pc_load_addr(pc_load_addr), .irq_taken(irq_taken), .irq_source(irq_source));
`default_nettype wire

// ===== testbench/prioritised_interrupt_controller_test.sv
// self-checking bench: registers, flag capture, priority entry, return and stack limit
`timescale 1ns/10ps
`default_nettype none
module prioritised_interrupt_controller_test;
  import pic_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_irq_pin, cpu_ready, cpu_ret;
  logic pc_load, irq_taken, wake_req, run, slow, ret_req;
  logic [5:0] ev;
  logic [3:0] ev_tm, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, c0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PC_W-1:0] cpu_pc_next, pc_load_addr, pc_val;
  logic [SRC_W-1:0] irq_source;
  logic [33:0] rd_q[$];
  logic [12:0] pc_q[$];
  logic [PC_W-1:0] stk_q[$];
  logic [7:0] msk [4] = '{8'h7F, 8'hFF, 8'h11, 8'hFF};
  logic [7:0] flg [4] = '{8'h50, 8'hF0, 8'h10, 8'hF0};
  int error_cnt, n_tests, cyc, seed;
  pic_top pic_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_irq_pin(ext_irq_pin), .ev_time_base_zero(ev[5]), .ev_time_base_one(ev[4]), .ev_serial_module(ev[3]),
    .ev_eeprom_write(ev[2]), .ev_conversion(ev[1]), .ev_uart(ev[0]), .ev_timer_match(ev_tm), .cpu_ready(cpu_ready),
    .cpu_pc_next(cpu_pc_next), .cpu_return_from_interrupt(cpu_ret), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .irq_taken(irq_taken), .irq_source(irq_source), .wake_req(wake_req));
  pic_cpu_model #(.PC_W(PC_W)) pic_cpu_model_inst (.aclk(aclk), .aresetn(aresetn), .run(run), .slow(slow),
    .ret_req(ret_req), .pc_val(pc_val), .cpu_ready(cpu_ready), .cpu_pc_next(cpu_pc_next),
    .cpu_return_from_interrupt(cpu_ret));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("Error timeout expected done seen hang");
      stop_test;
    end
  end
  task automatic chk_val(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pc(input logic [12:0] exp, input logic [12:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error pc_load expected %h seen %h", exp, got);
    end
  endtask
  // the watcher samples at the falling edge, where one-cycle pulses are settled
  always @(negedge aclk)
  begin
    if (aresetn && s_axi_rvalid && s_axi_rready)
      chk_val("rdata", rd_q.size() ? rd_q.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
    if (aresetn && pc_load)
      chk_pc(pc_q.size() ? pc_q.pop_front() : 'x, {irq_taken, pc_load_addr});
  end
  // no local wait limit in the bus tasks: a stuck slave runs into the bench timeout
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done, ahs, whs;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ahs = s_axi_awvalid && s_axi_awready;
      whs = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      if (done)
        chk_val("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
      @(posedge aclk);
      if (ahs)
        s_axi_awvalid <= 1'b0;
      if (whs)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done, ahs;
    done = 1'b0;
    rd_q.push_back({er, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ahs = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      @(posedge aclk);
      if (ahs)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [9:0] m);
    {ev, ev_tm} <= m;
    @(posedge aclk);
    {ev, ev_tm} <= 10'h000;
    @(posedge aclk);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (pc_q.size() != 0 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    if (pc_q.size() != 0)
      chk_val("pc_load", 34'h1, 34'h0);
  endtask
  // a resumed entry follows the pop at once, so its note is queued behind the return
  task automatic ret(input logic resume);
    pc_q.push_back({1'b0, stk_q.pop_back()});
    if (resume)
    begin
      pc_q.push_back({1'b1, 12'h020});
      stk_q.push_back(pc_val);
    end
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    drain;
  endtask
  initial
  begin
    seed = 32'h0314_608a;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ext_irq_pin, run, slow, ret_req, ev, ev_tm, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, pc_val} = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h14, 8'h00, RESP_SLVERR);
    axi_wr(8'h24, 8'hFF, RESP_SLVERR);
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(8'(4 * i), 8'h00, RESP_OKAY);
      axi_wr(8'(4 * i), 8'hFF, RESP_OKAY);
      axi_rd(8'(4 * i), msk[i], RESP_OKAY);
      axi_wr(8'(4 * i), 8'h00, RESP_OKAY);
    end
    ext_irq_pin <= 1'b1;
    pulse(10'h3FF);
    // the event wake pulse is over; the pin flag lands one edge later, behind its synchroniser
    @(negedge aclk);
    chk_val("wake", 34'h0, {33'h0, wake_req});
    @(negedge aclk);
    chk_val("wake", 34'h1, {33'h0, wake_req});
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 4; i++)
      axi_rd(8'(4 * i), flg[i], RESP_OKAY);
    run <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_wr(8'h04, 8'hFF, RESP_OKAY);
    axi_wr(8'h08, 8'h11, RESP_OKAY);
    axi_wr(8'h0C, 8'hFF, RESP_OKAY);
    axi_wr(8'h00, 8'h7E, RESP_OKAY);
    repeat (10) @(posedge aclk);
    c0 = 8'h7F;
    for (int k = 0; k < 8; k++)
    begin
      pc_val <= 12'($random(seed));
      slow <= k[0];
      pc_q.push_back({1'b1, 12'(4 + 4 * k)});
      axi_wr(8'h00, c0, RESP_OKAY);
      drain;
      chk_val("irq_source", 34'(k), {31'h0, irq_source});
      stk_q.push_back(pc_val);
      c0 = c0 & ~(k == 0 ? 8'h10 : k == 4 ? 8'h20 : k == 5 ? 8'h40 : 8'h00);
      if (k == 0)
        axi_rd(8'h00, c0 & 8'h7E, RESP_OKAY);
      if (k == 4)
        axi_rd(8'h0C, 8'hFF, RESP_OKAY);
      ret(1'b0);
    end
    slow <= 1'b0;
    for (int j = 0; j < 5; j++)
    begin
      pc_val <= 12'($random(seed));
      pulse(10'h010);
      if (j < 4)
        pc_q.push_back({1'b1, 12'h020});
      axi_wr(8'h00, 8'h01, RESP_OKAY);
      drain;
      if (j < 4)
        stk_q.push_back(pc_val);
    end
    repeat (10) @(posedge aclk);
    ret(1'b1);
    repeat (4) ret(1'b0);
    axi_rd(8'h10, 8'h3E, RESP_OKAY);
    stop_test;
  end
endmodule
`default_nettype wire
